/* hdl/bsr_pkg.sv */
/*
 * Shared constants and types for the burst-of-two separate-I/O SRAM port.
 * Assumes a single 125 MHz sampling clock; all pin timing is recovered
 * from edges of the sampled input and output clock pins.
 */
package bsr_pkg;
    // Organisation
    localparam int DATA_W = 36;
    localparam int BYTE_W = 9;
    localparam int ADDR_W = 19;
    // Sampling clock
    localparam int MCLK_PERIOD_NS = 8;
    // Stable input clock cycles needed to lock the DLL
    localparam int DLL_LOCK_PERIOD = 2048;
    // Input clock static time that resets the DLL
    localparam int CLK_STOP_NS = 30;
    localparam int CLK_STOP_CYC = (CLK_STOP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // Pin sampler reset value
    localparam logic SYNC_RST = 1'h0;

    typedef enum logic [1:0] {DLL_RESET, DLL_LOCKING, DLL_READY} bsr_dll_t;
    typedef enum logic {WR_IDLE, WR_BEAT2} bsr_wr_t;
endpackage

/* hdl/bsr_array.sv */
/*
 * Storage array with a two-word burst port: one write of both burst words
 * with per-byte enables, and a combinational read of both burst words.
 * Assumes the caller supplies the first burst address only.
 */
`timescale 1ns/100ps
module bsr_array #(
    parameter int ADDR_W = bsr_pkg::ADDR_W,
    parameter int DATA_W = bsr_pkg::DATA_W,
    parameter int BYTE_W = bsr_pkg::BYTE_W
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data0,
    input wire logic [DATA_W/BYTE_W-1:0] wr_be0,
    input wire logic [DATA_W-1:0] wr_data1,
    input wire logic [DATA_W/BYTE_W-1:0] wr_be1,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data0,
    output logic [DATA_W-1:0] rd_data1
);
    localparam int NB = DATA_W / BYTE_W;

    logic [DATA_W-1:0] mem [2**ADDR_W];
    wire [ADDR_W-1:0] wr_addr1;
    wire [ADDR_W-1:0] rd_addr1;

    // Second beat uses first address plus one, wrapping linearly
    assign wr_addr1 = wr_addr + ADDR_W'(1);
    assign rd_addr1 = rd_addr + ADDR_W'(1);
    assign rd_data0 = mem[rd_addr];
    assign rd_data1 = mem[rd_addr1];

    // Byte-masked commit of both burst words
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NB; i++) begin
            if (wr_en && wr_be0[i]) begin
                mem[wr_addr][i*BYTE_W +: BYTE_W] <= wr_data0[i*BYTE_W +: BYTE_W];
            end
            if (wr_en && wr_be1[i]) begin
                mem[wr_addr1][i*BYTE_W +: BYTE_W] <= wr_data1[i*BYTE_W +: BYTE_W];
            end
        end
    end
endmodule

/* hdl/bsr_port.sv */
/*
 * Device-side logic of a burst-of-two separate-I/O DDR SRAM: DLL lock and
 * reset sequencing, read and write command decode, read data return timing
 * and byte-masked writes through a one-burst write buffer.
 * Assumes all pins are asynchronous to mclk and that every input clock half
 * period spans at least three mclk cycles so each edge is seen.
 */
// Behaviour
// - DLL off tied low: ready after lock period
// - Static input clock over 30 ns resets DLL
// - DLL enable rising edge resets DLL
// - Second beat uses first address plus one
// - Read taken when read select sampled low
// - Write taken when write select sampled low
// - Read and write machines run concurrently
// - Transitions timed from true input clock
// - Read words at t+1.5 and t+2.0
// - Two active-low byte masks for 18 bits
// - Four active-low byte masks for 36 bits
// - Output clocks tied high: use input clocks
// - DLL bypassed: read latency one cycle
// - Buffered writes; reads see latest data
// - Idle read cycle keeps burst in progress
`timescale 1ns/100ps
module bsr_port #(
    parameter int ADDR_W = bsr_pkg::ADDR_W,
    parameter int DATA_W = bsr_pkg::DATA_W,
    parameter int LOCK_CYCLES = bsr_pkg::DLL_LOCK_PERIOD
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic dll_off_n,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [DATA_W/bsr_pkg::BYTE_W-1:0] byte_mask_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] d_in,
    output logic [DATA_W-1:0] q_out_ff,
    output logic q_oe_ff,
    output logic dev_ready_ff
);
    localparam int BW = bsr_pkg::BYTE_W;
    localparam int NB = DATA_W / BW;
    localparam int PW = 7 + NB + ADDR_W + DATA_W;
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int SW = $clog2(bsr_pkg::CLK_STOP_CYC + 1);

    logic [PW-1:0] s1_ff;
    logic [PW-1:0] s2_ff;
    logic [4:0] prev_ff;
    logic [SW-1:0] stop_cnt_ff;
    logic [LW-1:0] lock_cnt_ff;
    logic [LW-1:0] nxt_lock_cnt;
    bsr_pkg::bsr_dll_t dll_ff;
    bsr_pkg::bsr_dll_t nxt_dll;
    bsr_pkg::bsr_wr_t wr_ff;
    logic c_low_seen_ff;
    logic [DATA_W-1:0] wd0_ff;
    logic [NB-1:0] wm0_ff;
    logic wb_valid_ff;
    logic [ADDR_W-1:0] wb_addr_ff;
    logic [DATA_W-1:0] wb_d0_ff;
    logic [DATA_W-1:0] wb_d1_ff;
    logic [NB-1:0] wb_be0_ff;
    logic [NB-1:0] wb_be1_ff;
    logic a_valid_ff;
    logic b_valid_ff;
    logic [DATA_W-1:0] a_w0_ff;
    logic [DATA_W-1:0] a_w1_ff;
    logic [DATA_W-1:0] b_w0_ff;
    logic [DATA_W-1:0] b_w1_ff;
    logic [DATA_W-1:0] mem_rd0;
    logic [DATA_W-1:0] mem_rd1;

    // Two-flop sampling of every pin
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_ff <= {PW{bsr_pkg::SYNC_RST}};
            s2_ff <= {PW{bsr_pkg::SYNC_RST}};
        end else begin
            s1_ff <= {k_clk, k_clk_n, c_clk, c_clk_n, dll_off_n, rd_sel_n, wr_sel_n,
                      byte_mask_n, addr, d_in};
            s2_ff <= s1_ff;
        end
    end

    // Field selection from the sampled pins
    wire [DATA_W-1:0] s_data = s2_ff[DATA_W-1:0];
    wire [ADDR_W-1:0] s_addr = s2_ff[DATA_W +: ADDR_W];
    wire [NB-1:0] s_mask_n = s2_ff[DATA_W+ADDR_W +: NB];
    wire s_wr_n = s2_ff[PW-7];
    wire s_rd_n = s2_ff[PW-6];
    wire [4:0] s_clk = s2_ff[PW-1:PW-5];
    wire dll_on = s_clk[0];

    // Edge detection on the sampled clocks and the DLL enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_ff <= 5'h00;
        end else begin
            prev_ff <= s_clk;
        end
    end
    wire k_rise = s_clk[4] & ~prev_ff[4];
    wire kn_rise = s_clk[3] & ~prev_ff[3];
    wire c_rise = s_clk[2] & ~prev_ff[2];
    wire cn_rise = s_clk[1] & ~prev_ff[1];
    wire doff_rise = s_clk[0] & ~prev_ff[0];
    wire k_moved = (s_clk[4] ^ prev_ff[4]) | (s_clk[3] ^ prev_ff[3]);

    // Count mclk cycles with both input clocks static
    always_ff @(posedge mclk) begin
        if (!rst_n || k_moved) begin
            stop_cnt_ff <= SW'(0);
        end else if (stop_cnt_ff != SW'(bsr_pkg::CLK_STOP_CYC)) begin
            stop_cnt_ff <= stop_cnt_ff + SW'(1);
        end
    end
    wire k_stopped = (stop_cnt_ff == SW'(bsr_pkg::CLK_STOP_CYC));

    // DLL sequencing; the controller owns the order of clock and enable
    always_comb begin
        nxt_dll = dll_ff;
        nxt_lock_cnt = lock_cnt_ff;
        if (k_stopped || doff_rise) begin
            nxt_dll = bsr_pkg::DLL_RESET;
            nxt_lock_cnt = LW'(0);
        end else begin
            case (dll_ff)
                bsr_pkg::DLL_RESET: begin
                    nxt_dll = bsr_pkg::DLL_LOCKING;
                    nxt_lock_cnt = LW'(0);
                end
                bsr_pkg::DLL_LOCKING: begin
                    if (k_rise && lock_cnt_ff == LW'(LOCK_CYCLES - 1)) begin
                        nxt_dll = bsr_pkg::DLL_READY;
                    end else if (k_rise) begin
                        nxt_lock_cnt = lock_cnt_ff + LW'(1);
                    end
                end
                default: begin
                    nxt_dll = bsr_pkg::DLL_READY;
                end
            endcase
        end
    end

    // DLL state registers; rst_n stands in for power-up
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dll_ff <= bsr_pkg::DLL_RESET;
            lock_cnt_ff <= LW'(0);
            dev_ready_ff <= 1'h0;
        end else begin
            dll_ff <= nxt_dll;
            lock_cnt_ff <= nxt_lock_cnt;
            dev_ready_ff <= (nxt_dll == bsr_pkg::DLL_READY);
        end
    end

    // Command decode on the true input clock rise; second write beat on the K# rise
    wire rd_take = k_rise & dev_ready_ff & ~s_rd_n;
    wire wr_take = k_rise & dev_ready_ff & ~s_wr_n;
    wire wr_second = kn_rise & (wr_ff == bsr_pkg::WR_BEAT2);

    // Write machine: first beat at K, address and second beat at K#
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_ff <= bsr_pkg::WR_IDLE;
            wd0_ff <= {DATA_W{1'h0}};
            wm0_ff <= {NB{1'h0}};
        end else if (wr_take) begin
            wr_ff <= bsr_pkg::WR_BEAT2;
            wd0_ff <= s_data;
            wm0_ff <= ~s_mask_n;
        end else if (wr_second) begin
            wr_ff <= bsr_pkg::WR_IDLE;
        end
    end

    // Write buffer holds the latest burst until the next write commits it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_valid_ff <= 1'h0;
            wb_addr_ff <= {ADDR_W{1'h0}};
            wb_d0_ff <= {DATA_W{1'h0}};
            wb_d1_ff <= {DATA_W{1'h0}};
            wb_be0_ff <= {NB{1'h0}};
            wb_be1_ff <= {NB{1'h0}};
        end else if (wr_second) begin
            wb_valid_ff <= 1'h1;
            wb_addr_ff <= s_addr;
            wb_d0_ff <= wd0_ff;
            wb_d1_ff <= s_data;
            wb_be0_ff <= wm0_ff;
            wb_be1_ff <= ~s_mask_n;
        end
    end

    bsr_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .BYTE_W(BW)
    ) u_array (
        .mclk(mclk),
        .wr_en(wr_second & wb_valid_ff),
        .wr_addr(wb_addr_ff),
        .wr_data0(wb_d0_ff),
        .wr_be0(wb_be0_ff),
        .wr_data1(wb_d1_ff),
        .wr_be1(wb_be1_ff),
        .rd_addr(s_addr),
        .rd_data0(mem_rd0),
        .rd_data1(mem_rd1)
    );

    // Merge buffered bytes over array data for one burst word
    function automatic logic [DATA_W-1:0] fwd_word(input logic [ADDR_W-1:0] ra,
                                                   input logic [DATA_W-1:0] arr);
        logic [DATA_W-1:0] w;
        w = arr;
        for (int i = 0; i < NB; i++) begin
            if (wb_valid_ff && ra == wb_addr_ff && wb_be0_ff[i]) begin
                w[i*BW +: BW] = wb_d0_ff[i*BW +: BW];
            end
            if (wb_valid_ff && ra == wb_addr_ff + ADDR_W'(1) && wb_be1_ff[i]) begin
                w[i*BW +: BW] = wb_d1_ff[i*BW +: BW];
            end
        end
        return w;
    endfunction

    // A process, not an assign, so a change of the buffer alone redoes the merge
    logic [DATA_W-1:0] rd0_fwd;
    logic [DATA_W-1:0] rd1_fwd;
    always_comb begin
        rd0_fwd = fwd_word(s_addr, mem_rd0);
        rd1_fwd = fwd_word(s_addr + ADDR_W'(1), mem_rd1);
    end

    // Read machine: two-stage pipeline advanced by each K rise
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            a_valid_ff <= 1'h0;
            b_valid_ff <= 1'h0;
            a_w0_ff <= {DATA_W{1'h0}};
            a_w1_ff <= {DATA_W{1'h0}};
            b_w0_ff <= {DATA_W{1'h0}};
            b_w1_ff <= {DATA_W{1'h0}};
        end else if (k_rise) begin
            a_valid_ff <= rd_take;
            a_w0_ff <= rd0_fwd;
            a_w1_ff <= rd1_fwd;
            b_valid_ff <= a_valid_ff;
            b_w0_ff <= a_w0_ff;
            b_w1_ff <= b_valid_ff ? a_w1_ff : a_w1_ff;
        end
    end

    // Output clocks tied high from power-up select input clock timing; only a
    // real fall counts, so the samplers' zeros after reset are not taken as low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            c_low_seen_ff <= 1'h0;
        end else if ((prev_ff[2] && !s_clk[2]) || (prev_ff[1] && !s_clk[1])) begin
            c_low_seen_ff <= 1'h1;
        end
    end
    wire op_edge = c_low_seen_ff ? c_rise : k_rise;
    wire on_edge = c_low_seen_ff ? cn_rise : kn_rise;

    // Word edges: 1.5/2.0 with DLL, 1.0/1.5 with DLL bypassed
    wire w0_edge = dll_on ? on_edge : op_edge;
    wire w1_edge = dll_on ? op_edge : on_edge;
    wire w0_valid = dll_on ? b_valid_ff : a_valid_ff;
    wire [DATA_W-1:0] w0_data = dll_on ? b_w0_ff : a_w0_ff;

    // Output data register; idle slots release the bus
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_out_ff <= {DATA_W{1'h0}};
            q_oe_ff <= 1'h0;
        end else if (w0_edge) begin
            q_out_ff <= w0_data;
            q_oe_ff <= w0_valid;
        end else if (w1_edge) begin
            q_out_ff <= b_w1_ff;
            q_oe_ff <= b_valid_ff;
        end
    end

    // Checks
    a_stop_reset_dll: assert property (@(posedge mclk) disable iff (!rst_n)
        k_stopped |=> (dll_ff == bsr_pkg::DLL_RESET) && !dev_ready_ff)
        else $error("static input clock did not reset the DLL");
    a_doff_rise_reset: assert property (@(posedge mclk) disable iff (!rst_n)
        doff_rise |=> !dev_ready_ff ##1 (dll_ff == bsr_pkg::DLL_LOCKING))
        else $error("DLL enable rise did not restart locking");
    a_lock_then_ready: assert property (@(posedge mclk) disable iff (!rst_n)
        (dll_ff == bsr_pkg::DLL_LOCKING && k_rise && !k_stopped && !doff_rise
         && lock_cnt_ff == LW'(LOCK_CYCLES - 1)) |=> dev_ready_ff)
        else $error("device not ready after lock period");
    a_not_ready_early: assert property (@(posedge mclk) disable iff (!rst_n)
        (dll_ff == bsr_pkg::DLL_LOCKING) |-> !dev_ready_ff)
        else $error("ready raised while locking");
    a_write_beat_pair: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_take && !wr_second) |=> (wr_ff == bsr_pkg::WR_BEAT2) && wd0_ff == $past(s_data))
        else $error("first write beat not captured");
    a_idle_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (kn_rise && wr_ff == bsr_pkg::WR_IDLE) |=> $stable(wb_addr_ff))
        else $error("buffer changed without a write");
    a_mask_capture: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_second |=> wb_be1_ff == ~$past(s_mask_n))
        else $error("second beat byte mask wrong");
    a_read_pipe: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_take |=> a_valid_ff)
        else $error("read command not taken");
    a_nop_keeps_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (k_rise && a_valid_ff && !rd_take) |=> b_valid_ff && !a_valid_ff)
        else $error("idle cycle cut a read short");
    a_word_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        (w0_edge && w0_valid) |=> q_oe_ff && q_out_ff == $past(w0_data))
        else $error("first read word not driven");
endmodule

/* verif/bsr_ctl.sv */
/* Behavioural memory controller for the SRAM port: makes both clock pairs
 * and drives commands, addresses, masks and write beats.
 * Assumes an 8 ns mclk; the input clock half period is three mclk cycles. */
`timescale 1ns/100ps
module bsr_ctl (
    input wire logic mclk,
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output logic dll_off_n,
    output logic rd_sel_n,
    output logic wr_sel_n,
    output logic [bsr_pkg::DATA_W/bsr_pkg::BYTE_W-1:0] byte_mask_n,
    output logic [bsr_pkg::ADDR_W-1:0] addr,
    output logic [bsr_pkg::DATA_W-1:0] d_in
);
    logic [2:0] ph_ff = 3'h0;
    logic stop_ff = 1'h0;
    logic tie_ff = 1'h0;
    // Every pin at a defined level from time zero
    initial begin
        dll_off_n = 1'h0;
        rd_sel_n = 1'h1;
        wr_sel_n = 1'h1;
        byte_mask_n = '1;
        addr = '0;
        d_in = '0;
    end
    // Six-phase counter; a stop freezes both clock pins
    always @(posedge mclk) begin
        if (!stop_ff) begin
            ph_ff <= (ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
        end
    end
    // Output pair follows the input pair with no added skew, or is tied high
    assign k_clk = ph_ff >= 3'h3;
    assign k_clk_n = ~k_clk;
    assign c_clk = tie_ff | k_clk;
    assign c_clk_n = tie_ff | k_clk_n;
    // Waits a bounded number of edges for a phase
    task automatic wait_ph(input logic [2:0] p);
        repeat (12) begin
            if (ph_ff == p) break;
            @(posedge mclk);
            #1;
        end
        // A phase that never comes is a hang: count it and end the run
        if (ph_ff != p) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, ph_ff, p);
            tb_top.mismatches++;
            tb_top.finish_test();
        end
    endtask
    // Command and first beat, held across the K rise
    task automatic cmd(input logic r_n, input logic w_n, input logic [18:0] a,
            input logic [35:0] d, input logic [3:0] m);
        wait_ph(3'h2);
        rd_sel_n = r_n;
        wr_sel_n = w_n;
        addr = a;
        d_in = d;
        byte_mask_n = m;
        wait_ph(3'h3);
    endtask
    // Write address and second beat held until sampled with the K# rise,
    // then lines are scrambled
    task automatic beat1(input logic [18:0] a, input logic [35:0] d, input logic [3:0] m);
        wait_ph(3'h4);
        rd_sel_n = 1'h1;
        wr_sel_n = 1'h1;
        addr = a;
        d_in = d;
        byte_mask_n = m;
        wait_ph(3'h1);
        addr = ~a;
        d_in = ~d;
    endtask
    // Holds both input clocks static for n mclk cycles: a DLL reset
    task automatic stop_clk(input int n);
        wait_ph(3'h1);
        stop_ff = 1'h1;
        repeat (n) @(posedge mclk);
        #1;
        stop_ff = 1'h0;
    endtask
    // DLL pin raised only while clocks run
    task automatic set_pins(input logic dll, input logic tie);
        wait_ph(3'h1);
        dll_off_n = dll;
        tie_ff = tie;
    endtask
endmodule

/* verif/tb_top.sv */
/* Self-checking bench for the SRAM port: the controller model drives the
 * pins and a reference memory predicts every read word. Assumes bsr_pkg. */
`timescale 1ns/100ps
module tb_top;
    localparam int DW = bsr_pkg::DATA_W;
    localparam int AW = bsr_pkg::ADDR_W;
    localparam int NB = DW / bsr_pkg::BYTE_W;
    localparam int LOCK = 8;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic k_clk, k_clk_n, c_clk, c_clk_n, dll_off_n, rd_sel_n, wr_sel_n;
    logic [NB-1:0] byte_mask_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] d_in, q_out_ff;
    logic q_oe_ff, dev_ready_ff;
    logic idle_chk = 1'h0;
    logic byp = 1'h1;
    int ecnt = 0;
    int mismatches = 0;
    int samples_checked = 0;
    int due_q [$];
    logic [DW-1:0] exp_q [$];
    logic [DW-1:0] mem [int];
    // Sampling clock
    initial begin
        forever #4 mclk = ~mclk;
    end
    bsr_port #(.LOCK_CYCLES(LOCK)) DUT (.mclk(mclk), .rst_n(rst_n), .k_clk(k_clk),
        .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .dll_off_n(dll_off_n),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .byte_mask_n(byte_mask_n),
        .addr(addr), .d_in(d_in), .q_out_ff(q_out_ff), .q_oe_ff(q_oe_ff),
        .dev_ready_ff(dev_ready_ff));
    bsr_ctl ctl (.mclk(mclk), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
        .c_clk_n(c_clk_n), .dll_off_n(dll_off_n), .rd_sel_n(rd_sel_n),
        .wr_sel_n(wr_sel_n), .byte_mask_n(byte_mask_n), .addr(addr), .d_in(d_in));
    task automatic finish_test();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Edge counter; each read word is checked in the last mclk cycle of its window
    always @(posedge mclk) begin
        ecnt <= ecnt + 1;
        #1;
        if (due_q.size() > 0 && due_q[0] == ecnt) begin
            chk(q_oe_ff, 1'h1);
            chk(q_out_ff, exp_q[0]);
            void'(due_q.pop_front());
            void'(exp_q.pop_front());
        end else if (idle_chk && (ctl.ph_ff == 3'h2 || ctl.ph_ff == 3'h5)) begin
            chk(q_oe_ff, 1'h0);
        end
    end
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
            input logic [DW-1:0] d, input logic [NB-1:0] m);
        merge = old;
        for (int i = 0; i < NB; i++) begin
            if (!m[i]) merge[i*9 +: 9] = d[i*9 +: 9];
        end
    endfunction
    // One input clock cycle: optional read and optional write
    task automatic op(input logic r, input logic w, input logic [AW-1:0] ra,
            input logic [AW-1:0] wa, input logic [DW-1:0] d0, input logic [DW-1:0] d1,
            input logic [NB-1:0] m0, input logic [NB-1:0] m1);
        logic [AW-1:0] r1;
        logic [AW-1:0] w1;
        r1 = ra + 19'h1;
        w1 = wa + 19'h1;
        ctl.cmd(~r, ~w, ra, d0, m0);
        if (r && dev_ready_ff) begin
            due_q.push_back(ecnt + (byp ? 11 : 14));
            exp_q.push_back(mem[ra]);
            due_q.push_back(ecnt + (byp ? 14 : 17));
            exp_q.push_back(mem[r1]);
        end
        if (w && dev_ready_ff) begin
            mem[wa] = merge(mem.exists(wa) ? mem[wa] : d0, d0, m0);
            mem[w1] = merge(mem.exists(w1) ? mem[w1] : d1, d1, m1);
        end
        ctl.beat1(wa, d1, m1);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, input logic [DW-1:0] d1);
        op(1'h0, 1'h1, a, a, d0, d1, 4'h0, 4'h0);
    endtask
    task automatic rd(input logic [AW-1:0] a);
        op(1'h1, 1'h0, a, ~a, 36'h0, 36'hfffffffff, 4'h0, 4'h0);
    endtask
    task automatic gap(input int n);
        repeat (n * 6) @(posedge mclk);
        #1;
    endtask
    // Bounded wait for the ready flag to reach a level
    task automatic wait_rdy(input logic v, input int lim, output int n);
        n = 0;
        while (dev_ready_ff !== v) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > lim) begin
                mismatches++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, dev_ready_ff, v);
                finish_test();
            end
        end
    endtask
    task automatic t_bypass();
        int n;
        wait_rdy(1'h1, LOCK * 6 + 60, n);
        chk(n >= (LOCK - 1) * 6, 1'h1);
        idle_chk = 1'h1;
        wr(19'h100, 36'h123456789, 36'h9abcdef01);
        rd(19'h100);
        op(1'h1, 1'h1, 19'h100, 19'h100, 36'h5a5a5a5a5, 36'ha5a5a5a5a, 4'h0, 4'h0);
        rd(19'h100);
        gap(3);
    endtask
    task automatic t_dll_rise();
        int n;
        idle_chk = 1'h0;
        ctl.set_pins(1'h1, 1'h0);
        wait_rdy(1'h0, 12, n);
        wait_rdy(1'h1, LOCK * 6 + 60, n);
        chk(n >= (LOCK - 1) * 6, 1'h1);
        byp = 1'h0;
        idle_chk = 1'h1;
    endtask
    task automatic t_traffic();
        rd(19'h100);
        wr(19'h200, 36'h0f0f0f0f0, 36'hf0f0f0f0f);
        rd(19'h200);
        op(1'h0, 1'h0, 19'h200, 19'h200, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        rd(19'h200);
        rd(19'h100);
        wr(19'h7ffff, 36'h333333333, 36'h444444444);
        rd(19'h7ffff);
        gap(3);
        rd(19'h200);
        gap(3);
    endtask
    task automatic t_masks();
        logic [NB-1:0] tbl [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h0, 4'hf};
        logic [AW-1:0] a;
        for (int i = 0; i < 6; i++) begin
            a = 19'h300 + 19'(i * 2);
            wr(a, 36'h0aaaaaaaa, 36'h155555555);
            op(1'h1, 1'h1, a, a, 36'hfedcba987, 36'h13579bdf0, tbl[i], ~tbl[i]);
            rd(a);
        end
        for (int i = 0; i < 6; i++) begin
            rd(19'h300 + 19'(i * 2));
        end
        gap(3);
    endtask
    task automatic t_stop();
        int n;
        idle_chk = 1'h0;
        ctl.stop_clk(12);
        chk(dev_ready_ff, 1'h0);
        idle_chk = 1'h1;
        wr(19'h200, 36'h666666666, 36'h777777777);
        rd(19'h200);
        wait_rdy(1'h1, LOCK * 6 + 60, n);
        chk(n >= (LOCK - 3) * 6, 1'h1);
        rd(19'h200);
        gap(3);
    endtask
    task automatic t_single();
        int n;
        idle_chk = 1'h0;
        rst_n = 1'h0;
        ctl.set_pins(1'h1, 1'h1);
        gap(1);
        chk(q_oe_ff | dev_ready_ff, 1'h0);
        rst_n = 1'h1;
        wait_rdy(1'h1, LOCK * 6 + 60, n);
        idle_chk = 1'h1;
        wr(19'h400, 36'h888888888, 36'h999999999);
        rd(19'h400);
        gap(3);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        chk(dev_ready_ff, 1'h0);
        rst_n = 1'h1;
        t_bypass();
        t_dll_rise();
        t_traffic();
        t_masks();
        t_stop();
        t_single();
        finish_test();
    end
    // Hang guard
    initial begin
        #400000;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
        mismatches++;
        finish_test();
    end
endmodule
